// File: conv_pkg.sv
// shared constants and carriers for the dual converter front end
package conv_pkg;
  localparam int DATA_W = 8;
  localparam int CODE_W = 12;
  localparam int NUM_CONV = 2;
  // control register field positions
  localparam int EN_BIT = 7;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 3;
  localparam int FMT_HI = 2;
  localparam int FMT_LO = 0;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [11:0] CODE_RST = 12'h000;
  // update mode codes
  localparam logic [1:0] MODE_ON_HIGH = 2'h0;
  localparam logic [1:0] MODE_TMR3 = 2'h1;
  localparam logic [1:0] MODE_TMR4 = 2'h2;
  localparam logic [1:0] MODE_TMR2 = 2'h3;

  // one write from the processor side
  typedef struct packed {
    logic ctrl_wr;
    logic low_wr;
    logic high_wr;
    logic [7:0] wdata;
  } wr_req_t;

  // timer overflow pulses
  typedef struct packed {
    logic tmr2;
    logic tmr3;
    logic tmr4;
  } tmr_evt_t;

  // one converter's output side
  typedef struct packed {
    logic [11:0] code;
    logic out_oe;
  } conv_out_t;
endpackage

// File: conv_regs.sv
// holding store of data bytes for one converter, registered read data
module conv_regs
(
  input wire logic sys_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic low_wr, // low byte write strobe
  input wire logic high_wr, // high byte write strobe
  input wire logic [7:0] wdata, // write data
  output logic [7:0] low_q, // held low byte
  output logic [7:0] high_q // held high byte
);
  logic [7:0] low_d;
  logic [7:0] high_d;

  always_comb
  begin
    low_d = low_q;
    high_d = high_q;
    if (low_wr)
    begin
      low_d = wdata;
    end
    if (high_wr)
    begin
      high_d = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_q <= conv_pkg::BYTE_RST;
      high_q <= conv_pkg::BYTE_RST;
    end
    else
    begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end
endmodule

// File: dac_output_update_latch.sv
// digital front end of two 12-bit converters: registers, formats, latches
module dac_output_update_latch
(
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic nrst, // async reset, active low
  input wire conv_pkg::wr_req_t req0, // writes for converter 0
  input wire conv_pkg::wr_req_t req1, // writes for converter 1
  input wire conv_pkg::tmr_evt_t tmr, // timer overflow pulses
  input wire logic analog_bias_enable, // shared bias enable from software
  output logic [7:0] conv0_control_reg, // control register 0
  output logic [7:0] conv1_control_reg, // control register 1
  output conv_pkg::conv_out_t out0, // converter 0 latch and output enable
  output conv_pkg::conv_out_t out1, // converter 1 latch and output enable
  output logic bias_on // bias to analog cores, registered
);

  // ***********************************************************
  // format and mode helpers
  // ***********************************************************
  function automatic logic [11:0] assemble(input logic [2:0] fmt,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [15:0] w;
    w = {hi, lo};
    case (fmt)
      3'h0: assemble = w[11:0];
      3'h1: assemble = w[12:1];
      3'h2: assemble = w[13:2];
      3'h3: assemble = w[14:3];
      default: assemble = w[15:4];
    endcase
  endfunction

  function automatic logic tmr_hit(input logic [1:0] mode,
                                   input conv_pkg::tmr_evt_t t);
    case (mode)
      conv_pkg::MODE_TMR3: tmr_hit = t.tmr3;
      conv_pkg::MODE_TMR4: tmr_hit = t.tmr4;
      conv_pkg::MODE_TMR2: tmr_hit = t.tmr2;
      default: tmr_hit = 1'b0;
    endcase
  endfunction

  // ***********************************************************
  // per converter state
  // ***********************************************************
  conv_pkg::wr_req_t req [2];
  logic [7:0] ctrl_q [2];
  logic [7:0] ctrl_d [2];
  logic [7:0] low_q [2];
  logic [7:0] high_q [2];
  logic [11:0] code_q [2];
  logic [11:0] code_d [2];
  logic oe_q [2];
  logic oe_d [2];
  logic hwr_q [2];
  logic bias_q;

  assign req[0] = req0;
  assign req[1] = req1;

  genvar g;
  generate
    for (g = 0; g < conv_pkg::NUM_CONV; g++)
    begin : g_conv
      // held bytes; low byte writes never touch the latch
      conv_regs conv_regs_i
      (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .low_wr(req[g].low_wr),
        .high_wr(req[g].high_wr),
        .wdata(req[g].wdata),
        .low_q(low_q[g]),
        .high_q(high_q[g])
      );

      logic [1:0] mode;
      assign mode = ctrl_q[g][conv_pkg::MODE_HI:conv_pkg::MODE_LO];

      always_comb
      begin
        ctrl_d[g] = ctrl_q[g];
        if (req[g].ctrl_wr)
        begin
          // bits 6 and 5 unused, kept zero
          ctrl_d[g] = req[g].wdata & 8'h9F;
        end
        code_d[g] = code_q[g];
        // one cycle after the strobe, bytes already held
        if (hwr_q[g] && mode == conv_pkg::MODE_ON_HIGH)
        begin
          code_d[g] = assemble(ctrl_q[g][conv_pkg::FMT_HI:conv_pkg::FMT_LO],
                               high_q[g], low_q[g]);
        end
        else if (tmr_hit(mode, tmr))
        begin
          code_d[g] = assemble(ctrl_q[g][conv_pkg::FMT_HI:conv_pkg::FMT_LO],
                               high_q[g], low_q[g]);
        end
        oe_d[g] = ctrl_q[g][conv_pkg::EN_BIT];
      end

      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          ctrl_q[g] <= conv_pkg::CTRL_RST;
          code_q[g] <= conv_pkg::CODE_RST;
          oe_q[g] <= 1'b0;
          hwr_q[g] <= 1'b0;
        end
        else
        begin
          ctrl_q[g] <= ctrl_d[g];
          code_q[g] <= code_d[g];
          oe_q[g] <= oe_d[g];
          hwr_q[g] <= req[g].high_wr;
        end
      end

      a_hold_low: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!hwr_q[g] && ctrl_q[g][4:3] == 2'h0) |=> $stable(code_q[g]))
        else $error("latch changed without high write");
      // held bytes of the load cycle; a write there is not yet seen
      a_high_load: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (req[g].high_wr && ctrl_q[g][4:0] == 5'h00 && !req[g].ctrl_wr
         && !req[g].low_wr) ##1 !req[g].ctrl_wr
        |=> code_q[g] == {$past(high_q[g][3:0]), $past(low_q[g])})
        else $error("latch not loaded after high write");
      a_off_float: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !ctrl_q[g][7] |=> !oe_q[g])
        else $error("output driven while disabled");
      a_tmr3_load: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (ctrl_q[g][4:3] == 2'h1 && tmr.tmr3)
        |=> code_q[g] == assemble($past(ctrl_q[g][2:0]),
                                  $past(high_q[g]), $past(low_q[g])))
        else $error("timer 3 update missed");
    end
  endgenerate

  // bias only passes through; the converters do not gate on it
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bias_q <= 1'b0;
    end
    else
    begin
      bias_q <= analog_bias_enable;
    end
  end

  assign conv0_control_reg = ctrl_q[0];
  assign conv1_control_reg = ctrl_q[1];
  assign out0 = '{code: code_q[0], out_oe: oe_q[0]};
  assign out1 = '{code: code_q[1], out_oe: oe_q[1]};
  assign bias_on = bias_q;

  a_rst_zero: assert property (@(posedge sys_clk)
    $rose(nrst) |-> ctrl_q[0] == 8'h00 && ctrl_q[1] == 8'h00)
    else $error("control not zero after reset");
  a_en_follow: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    req1.ctrl_wr |=> ##1 oe_q[1] == $past(req1.wdata[7], 2))
    else $error("enable 1 not followed");
  a_fmt_wide: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (hwr_q[1] && ctrl_q[1][4:2] == 3'h1)
    |=> code_q[1] == {$past(high_q[1]), $past(low_q[1][7:4])})
    else $error("left aligned format wrong");
endmodule

// File: dac_output_update_latch_test.sv
// self-checking bench for the dual converter front end
module dac_output_update_latch_test;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
  logic sys_clk = 1'b0, nrst = 1'b0, analog_bias_enable = 1'b0, bias_on;
  conv_pkg::wr_req_t req0 = '0, req1 = '0;
  conv_pkg::tmr_evt_t tmr = '0;
  logic [7:0] conv0_control_reg, conv1_control_reg;
  conv_pkg::conv_out_t out0, out1;
  int bad_count = 0, total_checks = 0, cyc = 0;
  dac_output_update_latch dac_output_update_latch_i (.sys_clk(sys_clk),
    .nrst(nrst), .req0(req0), .req1(req1), .tmr(tmr), .bias_on(bias_on),
    .analog_bias_enable(analog_bias_enable), .out0(out0), .out1(out1),
    .conv0_control_reg(conv0_control_reg),
    .conv1_control_reg(conv1_control_reg));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      bad_count++;
      complete_run();
    end
  end
  // ********************
  // drivers and scenarios
  // ********************
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input int c, input int k, input logic [7:0] d);
    conv_pkg::wr_req_t r;
    r = '{ctrl_wr: k == 0, low_wr: k == 1, high_wr: k == 2, wdata: d};
    @(negedge sys_clk);
    if (c == 0) req0 = r; else if (c == 1) req1 = r; else tmr = d[2:0];
    @(negedge sys_clk);
    {req0, req1, tmr} = '0;
  endtask
  function automatic logic [11:0] fw(input logic [2:0] f,
                                     input logic [7:0] h, input logic [7:0] l);
    fw = f[2] ? {h, l[7:4]} : 12'({h, l} >> f);
  endfunction
  task automatic word(input int c, input logic [7:0] l, input logic [7:0] h);
    wr(c, 1, l);
    wr(c, 2, h);
    wt(3);
  endtask
  task automatic t_reset();
    `CHK(conv0_control_reg, 8'h00)
    `CHK(conv1_control_reg, 8'h00)
    `CHK({out0, out1, bias_on}, 27'h0000000)
    analog_bias_enable = 1'b1;
    wt(2);
    `CHK(bias_on, 1'b1)
    $display("test reset done");
  endtask
  task automatic t_enable();
    wr(0, 0, 8'hE7);
    wt(3);
    `CHK(conv0_control_reg, 8'h87)
    `CHK({out0.out_oe, out1.out_oe}, 2'h2)
    wr(0, 0, 8'h00);
    wt(3);
    `CHK(out0.out_oe, 1'b0)
    $display("test enable done");
  endtask
  task automatic t_formats();
    logic [2:0] f;
    for (int i = 0; i < 6; i++)
    begin
      f = (i == 5) ? 3'h7 : 3'(i);
      wr(0, 0, {5'h10, f});
      word(0, 8'hC3, 8'h5A + 8'(i));
      `CHK(out0.code, fw(f, 8'h5A + 8'(i), 8'hC3))
    end
    wr(0, 0, 8'h80);
    word(0, 8'hFF, 8'h0F);
    `CHK(out0.code, 12'hFFF)
    wr(0, 1, 8'h00);
    wt(3);
    `CHK(out0.code, 12'hFFF)
    wr(0, 2, 8'h00);
    wt(3);
    `CHK(out0.code, 12'h000)
    $display("test formats done");
  endtask
  task automatic t_timer();
    logic [2:0] ok;
    for (int m = 1; m < 4; m++)
    begin
      ok = (m == 1) ? 3'h2 : (m == 2) ? 3'h1 : 3'h4;
      wr(0, 0, 8'h80 | 8'(m << 3));
      word(0, 8'h11 * 8'(m), 8'(m));
      `CHK(out0.code, 12'h000)
      wr(2, 0, {5'h00, ~ok});
      `CHK(out0.code, 12'h000)
      wr(2, 0, {5'h00, ok});
      `CHK(out0.code, {4'(m), 8'h11 * 8'(m)})
      wr(0, 0, 8'h80);
      word(0, 8'h00, 8'h00);
    end
    $display("test timer done");
  endtask
  task automatic t_second();
    wr(1, 0, 8'h84);
    word(1, 8'h9C, 8'hE1);
    `CHK(out1.code, 12'hE19)
    `CHK({out1.out_oe, out0.code}, 13'h1000)
    `CHK(conv1_control_reg, 8'h84)
    $display("test second done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    wt(6);
    nrst = 1'b1;
    wt(1);
    t_reset();
    t_enable();
    t_formats();
    t_timer();
    t_second();
    complete_run();
  end
endmodule
